/* File: ipl_bank_if.sv */
// Carrier between the register decoder and one level register bank
`timescale 1ns/1ps
`default_nettype none
interface ipl_bank_if;
   import ipl_pkg::*;

   logic             wrEn;
   logic [1:0]       wrStrb;
   logic [REG_W-1:0] wrData;
   logic [REG_W-1:0] rdData;

   modport ctrl (output wrEn, output wrStrb, output wrData, input rdData);
   modport bank (input wrEn, input wrStrb, input wrData, output rdData);
endinterface : ipl_bank_if
`default_nettype wire

/* File: ipl_level_bank.sv */
// One 16-bit register of four 3-bit priority level fields
`timescale 1ns/1ps
`default_nettype none
module ipl_level_bank
   import ipl_pkg::*;
(
   input wire logic core_clk,
   input wire logic reset,
   ipl_bank_if.bank bus
);

   logic [REG_W-1:0] levelQ;
   logic [REG_W-1:0] levelD;
   logic [REG_W-1:0] laneMask;

   // ==========================================================
   // Byte lanes select which half is replaced
   assign laneMask = {{8{bus.wrStrb[1]}}, {8{bus.wrStrb[0]}}};
   assign levelD   = ((levelQ & ~laneMask) | (bus.wrData & laneMask))
                     & LEVEL_FIELD_MASK;                  // (RQ4)

   // Reset puts every field at the top level
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         levelQ <= LEVEL_RESET;                           // (RQ5)
      end else if (bus.wrEn) begin
         levelQ <= levelD;                                // (RQ2)
      end
   end

   // Reserved bits can never hold a one, so they read as zero
   assign bus.rdData = levelQ & LEVEL_FIELD_MASK;         // (RQ4)

endmodule : ipl_level_bank
`default_nettype wire

/* File: ipl_pkg.sv */
// Shared constants and types for the interrupt priority level bank block
package ipl_pkg;

   // ==========================================================
   // Geometry of the level registers
   localparam int unsigned NUM_BANKS       = 10;
   localparam int unsigned FIELDS_PER_BANK = 4;
   localparam int unsigned LEVEL_W         = 3;
   localparam int unsigned REG_W           = 16;
   localparam int unsigned NUM_FIELDS      = NUM_BANKS * FIELDS_PER_BANK;
   localparam int unsigned FIELD_IDX_W     = 6;
   localparam int unsigned APB_DATA_W      = 32;

   // ==========================================================
   // Field positions inside one level register
   localparam int unsigned LEVEL_FIELD_LOWER_LSB   = 0;
   localparam int unsigned LEVEL_FIELD_MIDLOW_LSB  = 4;
   localparam int unsigned LEVEL_FIELD_MIDHIGH_LSB = 8;
   localparam int unsigned LEVEL_FIELD_UPPER_LSB   = 12;

   // Writable bits; bits 15, 11, 7 and 3 stay zero
   localparam logic [REG_W-1:0] LEVEL_FIELD_MASK = 16'h7777;
   // Every field starts at the top level
   localparam logic [REG_W-1:0] LEVEL_RESET      = 16'h7777;
   localparam logic [LEVEL_W-1:0] LEVEL_TOP      = 3'h7;

   // ==========================================================
   // Register byte offsets on the APB
   localparam logic [7:0] SOURCE_LEVEL_BANK_A_OFS = 8'h00;
   localparam logic [7:0] SOURCE_LEVEL_BANK_B_OFS = 8'h04;
   localparam logic [7:0] SOURCE_LEVEL_BANK_C_OFS = 8'h08;
   localparam logic [7:0] SOURCE_LEVEL_BANK_E_OFS = 8'h0C;
   localparam logic [7:0] SOURCE_LEVEL_BANK_F_OFS = 8'h10;
   localparam logic [7:0] SOURCE_LEVEL_BANK_G_OFS = 8'h14;
   localparam logic [7:0] SOURCE_LEVEL_BANK_H_OFS = 8'h18;
   localparam logic [7:0] SOURCE_LEVEL_BANK_I_OFS = 8'h1C;
   localparam logic [7:0] SOURCE_LEVEL_BANK_K_OFS = 8'h20;
   localparam logic [7:0] SOURCE_LEVEL_BANK_L_OFS = 8'h24;

   // Offsets indexed by bank number, bank A first
   localparam logic [NUM_BANKS-1:0][7:0] BANK_OFS = {
      SOURCE_LEVEL_BANK_L_OFS, SOURCE_LEVEL_BANK_K_OFS,
      SOURCE_LEVEL_BANK_I_OFS, SOURCE_LEVEL_BANK_H_OFS,
      SOURCE_LEVEL_BANK_G_OFS, SOURCE_LEVEL_BANK_F_OFS,
      SOURCE_LEVEL_BANK_E_OFS, SOURCE_LEVEL_BANK_C_OFS,
      SOURCE_LEVEL_BANK_B_OFS, SOURCE_LEVEL_BANK_A_OFS};

   // ==========================================================
   // APB slave states
   typedef enum logic [1:0] {
      ST_IDLE   = 2'b01,
      ST_ACCESS = 2'b10
   } ipl_state_t;

   // Source s takes field s unless the integrator says otherwise
   function automatic logic [NUM_FIELDS*FIELD_IDX_W-1:0] ipl_identity_map();
      logic [NUM_FIELDS*FIELD_IDX_W-1:0] m;
      m = '0;
      for (int i = 0; i < NUM_FIELDS; i++) begin
         m[i*FIELD_IDX_W +: FIELD_IDX_W] = FIELD_IDX_W'(i);
      end
      return m;
   endfunction : ipl_identity_map

   localparam logic [NUM_FIELDS*FIELD_IDX_W-1:0] SRC_MAP_IDENTITY =
      ipl_identity_map();

endpackage : ipl_pkg

/* File: ipl_priority_levels.sv */
// APB register bank holding programmable interrupt priority levels
//
// Functional notes
// (RQ1) Levels 0..7 for all maskable sources, none NMI
// (RQ2) Four 3-bit fields per 16-bit register
// (RQ3) Field is unsigned, 000 lowest, 111 highest
// (RQ4) Bits 15, 11, 7, 3 read zero
// (RQ5) Reset sets all field bits to one
// (RQ6) Parameter table maps fields to sources; continuous
`timescale 1ns/1ps
`default_nettype none
module ipl_priority_levels
   import ipl_pkg::*;
#(
   parameter int unsigned ADDR_W      = 8,
   parameter int unsigned NUM_SOURCES = ipl_pkg::NUM_FIELDS,
   parameter logic [ipl_pkg::NUM_FIELDS*ipl_pkg::FIELD_IDX_W-1:0]
                          SRC_MAP     = ipl_pkg::SRC_MAP_IDENTITY
)(
   input  wire logic                                  core_clk,
   input  wire logic                                  reset,
   input  wire logic                                  psel,
   input  wire logic                                  penable,
   input  wire logic                                  pwrite,
   input  wire logic [ADDR_W-1:0]                     paddr,
   input  wire logic [ipl_pkg::APB_DATA_W-1:0]        pwdata,
   input  wire logic [ipl_pkg::APB_DATA_W/8-1:0]      pstrb,
   output logic      [ipl_pkg::APB_DATA_W-1:0]        prdata,
   output logic                                       pready,
   output logic                                       pslverr,
   output logic      [NUM_SOURCES*ipl_pkg::LEVEL_W-1:0] srcLevel,
   output logic      [NUM_SOURCES-1:0]                srcAtTop
);

   // ==========================================================
   // Elaboration checks
   // The decoder compares 8-bit offsets, so the bus needs 8 bits at least
   if (ADDR_W < 8) begin : g_bad_addr
      $error("ADDR_W must be at least 8");
   end
   // A source can only take a level from a field that exists
   if (NUM_SOURCES < 1 || NUM_SOURCES > NUM_FIELDS) begin : g_bad_src
      $error("NUM_SOURCES out of range");
   end
   for (genvar s = 0; s < NUM_SOURCES; s++) begin : g_map_chk
      if (SRC_MAP[s*FIELD_IDX_W +: FIELD_IDX_W] >= NUM_FIELDS)
      begin : g_bad_entry
         $error("SRC_MAP entry points past the last field");
      end
   end

   // ==========================================================
   // Declarations
   ipl_state_t                     stateQ;
   ipl_state_t                     stateD;
   logic [APB_DATA_W-1:0]          prdataQ;
   logic [APB_DATA_W-1:0]          prdataD;
   logic                           preadyQ;
   logic                           pslverrQ;
   logic                           pslverrD;
   logic                           setupPhase;
   logic                           accessDone;
   logic                           addrAligned;
   logic [NUM_BANKS-1:0]           bankHit;
   logic                           anyHit;
   logic [NUM_BANKS-1:0][REG_W-1:0] bankRd;
   logic [REG_W-1:0]               readMux;
   logic [NUM_FIELDS*LEVEL_W-1:0]  allFields;
   logic [NUM_SOURCES*LEVEL_W-1:0] srcLevelD;
   logic [NUM_SOURCES*LEVEL_W-1:0] srcLevelQ;
   logic [NUM_SOURCES-1:0]         srcAtTopD;
   logic [NUM_SOURCES-1:0]         srcAtTopQ;

   ipl_bank_if bankBus [NUM_BANKS] ();

   // ==========================================================
   // APB phase decode
   assign setupPhase  = psel & ~penable;
   // The write lands at the edge where the master sees pready high
   assign accessDone  = psel & penable & preadyQ & (stateQ == ST_ACCESS);
   assign addrAligned = (paddr[1:0] == 2'b00);

   // ==========================================================
   // Address decode against the offset table
   for (genvar b = 0; b < NUM_BANKS; b++) begin : g_decode
      assign bankHit[b] = addrAligned
         & (paddr[ADDR_W-1:0] == ADDR_W'(BANK_OFS[b]));
   end
   assign anyHit = |bankHit;

   // ==========================================================
   // Register banks, one leaf per register
   for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
      // Only mapped, completing writes reach the storage
      assign bankBus[b].wrEn   = accessDone & pwrite & bankHit[b];
      assign bankBus[b].wrStrb = pstrb[1:0];
      assign bankBus[b].wrData = pwdata[REG_W-1:0];
      assign bankRd[b]         = bankBus[b].rdData;

      ipl_level_bank u_bank (
         .core_clk (core_clk),
         .reset    (reset),
         .bus      (bankBus[b])
      );
   end

   // ==========================================================
   // Read selection; at most one bank hits, so an OR tree suffices
   always_comb begin
      readMux = '0;
      for (int b = 0; b < NUM_BANKS; b++) begin
         readMux = readMux | (bankRd[b] & {REG_W{bankHit[b]}});
      end
   end

   // Upper half of the word reads as zero
   assign prdataD  = {{(APB_DATA_W-REG_W){1'b0}}, readMux};
   // Unmapped or unaligned addresses answer with an error, no side effect
   assign pslverrD = ~anyHit;

   // ==========================================================
   // Slave state machine: one wait-free access phase per transfer
   always_comb begin
      stateD = stateQ;
      case (stateQ)
         ST_IDLE: begin
            if (setupPhase) begin
               stateD = ST_ACCESS;
            end
         end
         ST_ACCESS: begin
            if (accessDone || !psel) begin
               stateD = ST_IDLE;
            end
         end
         default: begin
            stateD = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         stateQ <= ST_IDLE;
      end else begin
         stateQ <= stateD;
      end
   end

   // ==========================================================
   // Answer registers; captured at the end of setup and held
   // through the access phase so prdata stays stable
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         preadyQ  <= 1'b0;
         pslverrQ <= 1'b0;
         prdataQ  <= '0;
      end else if (stateQ == ST_IDLE && setupPhase) begin
         preadyQ  <= 1'b1;
         pslverrQ <= pslverrD;
         prdataQ  <= pwrite ? '0 : prdataD;
      end else if (stateQ == ST_ACCESS) begin
         // Drop the answer after the handshake so it cannot repeat
         preadyQ  <= 1'b0;
         pslverrQ <= 1'b0;
         prdataQ  <= '0;
      end
   end

   assign prdata  = prdataQ;
   assign pready  = preadyQ;
   assign pslverr = pslverrQ;

   // ==========================================================
   // Flatten all fields, bank A lower field as index 0
   for (genvar b = 0; b < NUM_BANKS; b++) begin : g_flat
      assign allFields[(b*FIELDS_PER_BANK+0)*LEVEL_W +: LEVEL_W] =
         bankRd[b][LEVEL_FIELD_LOWER_LSB +: LEVEL_W];     // (RQ2)
      assign allFields[(b*FIELDS_PER_BANK+1)*LEVEL_W +: LEVEL_W] =
         bankRd[b][LEVEL_FIELD_MIDLOW_LSB +: LEVEL_W];    // (RQ2)
      assign allFields[(b*FIELDS_PER_BANK+2)*LEVEL_W +: LEVEL_W] =
         bankRd[b][LEVEL_FIELD_MIDHIGH_LSB +: LEVEL_W];   // (RQ2)
      assign allFields[(b*FIELDS_PER_BANK+3)*LEVEL_W +: LEVEL_W] =
         bankRd[b][LEVEL_FIELD_UPPER_LSB +: LEVEL_W];     // (RQ2)
   end

   // ==========================================================
   // Route each field to its source through the parameter table.
   // Only maskable sources appear here; NMI has no entry at all.
   for (genvar s = 0; s < NUM_SOURCES; s++) begin : g_route
      localparam int unsigned FIDX =
         int'(SRC_MAP[s*FIELD_IDX_W +: FIELD_IDX_W]);
      assign srcLevelD[s*LEVEL_W +: LEVEL_W] =
         allFields[FIDX*LEVEL_W +: LEVEL_W];              // (RQ6) (RQ1)
      // Plain unsigned compare: 111 is the highest level
      assign srcAtTopD[s] =
         (allFields[FIDX*LEVEL_W +: LEVEL_W] == LEVEL_TOP); // (RQ3)
   end

   // Levels follow the registers one cycle after each write
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         srcLevelQ <= {NUM_SOURCES{LEVEL_TOP}};           // (RQ5)
         srcAtTopQ <= '1;
      end else begin
         srcLevelQ <= srcLevelD;                          // (RQ6)
         srcAtTopQ <= srcAtTopD;
      end
   end

   assign srcLevel = srcLevelQ;
   assign srcAtTop = srcAtTopQ;

endmodule : ipl_priority_levels
`default_nettype wire

/* File: ipl_properties.sv */
// Concurrent checks on the ports of the priority level bank
`timescale 1ns/1ps
`default_nettype none
module ipl_properties
   import ipl_pkg::*;
#(
   parameter int unsigned ADDR_W      = 8,
   parameter int unsigned NUM_SOURCES = ipl_pkg::NUM_FIELDS
)(
   input wire logic                         core_clk,
   input wire logic                         reset,
   input wire logic                         psel,
   input wire logic                         penable,
   input wire logic                         pwrite,
   input wire logic [ADDR_W-1:0]            paddr,
   input wire logic [31:0]                  pwdata,
   input wire logic [3:0]                   pstrb,
   input wire logic [31:0]                  prdata,
   input wire logic                         pready,
   input wire logic                         pslverr,
   input wire logic [NUM_SOURCES*3-1:0]     srcLevel,
   input wire logic [NUM_SOURCES-1:0]       srcAtTop
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset);

   // ==========================================================
   // Helper decode
   logic                   wrDone;
   logic                   badAddr;
   logic [NUM_SOURCES-1:0] topCalc;
   assign wrDone  = psel && penable && pready && pwrite;
   assign badAddr = (paddr > ADDR_W'(SOURCE_LEVEL_BANK_L_OFS))
                    || (paddr[1:0] != 2'b00);
   // Top flag recomputed per source
   always_comb begin
      for (int s = 0; s < NUM_SOURCES; s++) begin
         topCalc[s] = (srcLevel[3*s +: 3] == LEVEL_TOP);
      end
   end

   // ==========================================================
   // Transfer phases
   sequence sSetup;
      psel && !penable;
   endsequence
   sequence sWrA;
      psel && penable && pready && pwrite && paddr == '0
      && pstrb[1:0] == 2'b11 && !pslverr;
   endsequence

   a_reserved_bits_zero: assert property (
      pready && !pwrite |-> (prdata & 32'hFFFF8888) == 32'h0)
      else $error("reserved read bits not zero");
   a_top_flag_match: assert property (srcAtTop == topCalc)
      else $error("top flag disagrees with level");
   a_reset_all_top: assert property ($fell(reset) |-> &srcLevel)
      else $error("levels not at top after reset");
   a_write_fields_a: assert property (
      sSetup ##1 sWrA |-> ##2
      {srcLevel[11:9], srcLevel[2:0]} ==
      {$past(pwdata[14:12], 2), $past(pwdata[2:0], 2)})
      else $error("bank A fields not shown on levels");
   a_bad_addr_err: assert property (
      sSetup and badAddr |=> pready && pslverr)
      else $error("bad address not refused");
   a_level_cause: assert property (
      $changed(srcLevel) |-> $past(wrDone, 2))
      else $error("level changed without a write");
   a_pready_pulse: assert property (pready |=> !pready)
      else $error("pready held over two cycles");
endmodule : ipl_properties
`default_nettype wire

/* File: tb.sv */
// Self-checking bench for the priority level register bank
`timescale 1ns/1ps
`default_nettype none
module tb;
   import ipl_pkg::*;
   logic         core_clk = 1'b0;
   logic         reset    = 1'b1;
   logic         psel     = 1'b0;
   logic         penable  = 1'b0;
   logic         pwrite   = 1'b0;
   logic [7:0]   paddr    = 8'h00;
   logic [31:0]  pwdata   = 32'h0;
   logic [3:0]   pstrb    = 4'h0;
   logic [31:0]  prdata;
   logic         pready;
   logic         pslverr;
   logic [119:0] srcLevel;
   logic [39:0]  srcAtTop;
   logic [15:0]  model [10];
   int           numErrors = 0;
   int           nChecks   = 0;

   ipl_priority_levels DUT (.core_clk(core_clk), .reset(reset),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .srcLevel(srcLevel), .srcAtTop(srcAtTop));

   always #2.5 core_clk = ~core_clk;

   // ==========================================================
   // Compare, report and close
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      nChecks++;
      if (got !== exp) begin
         numErrors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check

   task automatic summarize();
      $display("Checks %0d, errors %0d", nChecks, numErrors);
      if (numErrors == 0 && nChecks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : summarize

   // ==========================================================
   // One APB transfer; the wait for pready is bounded
   task automatic xfer(input logic wr, input logic [7:0] a,
         input logic [31:0] d, input logic [3:0] s, input logic [31:0] exp,
         input logic expErr);
      int n;
      n = 0;
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge core_clk);
      penable <= 1'b1;
      do begin
         @(posedge core_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         numErrors++;
         summarize();
      end
      if (!wr) check(prdata, exp);
      check({31'h0, pslverr}, {31'h0, expErr});
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : xfer

   // Levels lag the write by one edge, so wait two edges before comparing
   task automatic chkLevels();
      repeat (2) @(posedge core_clk);
      #1;
      for (int s = 0; s < 40; s++) begin
         check(32'(srcLevel[3*s +: 3]), 32'(model[s/4][(s%4)*4 +: 3]));
         check(32'(srcAtTop[s]),
               32'(model[s/4][(s%4)*4 +: 3] == 3'h7));
      end
   endtask : chkLevels

   task automatic readAll();
      for (int b = 0; b < 10; b++) xfer(0, BANK_OFS[b], 0, 0, model[b], 0);
   endtask : readAll

   // ==========================================================
   // Main sequence
   initial begin
      for (int b = 0; b < 10; b++) model[b] = 16'h7777;
      repeat (4) @(posedge core_clk);
      reset <= 1'b0;
      chkLevels();
      readAll();
      // Ones into reserved bits must not stick
      for (int b = 0; b < 10; b++) xfer(1, BANK_OFS[b], '1, 4'hF, 0, 0);
      readAll();
      // Distinct codes per field; all eight codes appear
      for (int b = 0; b < 10; b++) begin
         model[b] = {1'b0, 3'(b + 3), 1'b0, 3'(b + 2), 1'b0, 3'(b + 1),
                     1'b0, 3'(b)};
         xfer(1, BANK_OFS[b], 32'(model[b]), 4'h3, 0, 0);
      end
      chkLevels();
      readAll();
      // Low strobe alone leaves the high byte
      xfer(1, BANK_OFS[1], 0, 4'h1, 0, 0);
      model[1][7:0] = 8'h00;
      chkLevels();
      xfer(0, BANK_OFS[1], 0, 0, 32'(model[1]), 0);
      // Unmapped and unaligned places are refused
      xfer(1, 8'h28, 0, 4'hF, 0, 1);
      xfer(1, 8'h02, 0, 4'hF, 0, 1);
      xfer(0, 8'h28, 0, 0, 0, 1);
      readAll();
      // Reset in mid-run restores the top level
      @(posedge core_clk);
      reset <= 1'b1;
      repeat (2) @(posedge core_clk);
      reset <= 1'b0;
      for (int b = 0; b < 10; b++) model[b] = 16'h7777;
      chkLevels();
      readAll();
      summarize();
   end
endmodule : tb

bind ipl_priority_levels ipl_properties #(.ADDR_W(ADDR_W),
   .NUM_SOURCES(NUM_SOURCES)) uProps (.core_clk(core_clk), .reset(reset),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .srcLevel(srcLevel), .srcAtTop(srcAtTop));
`default_nettype wire
